/* File: logic/usb_xcvr_pkg.sv */
// Constants, field layouts and carrier types for the USB function front end
package usb_xcvr_pkg;

   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam logic [7:0] XCVR_CTRL_ADDR  = 8'hd7;
   localparam logic [7:0] PIPE_SEL_ADDR   = 8'h01;
   localparam logic [7:0] PIPE_DATA_ADDR  = 8'h02;
   localparam logic [7:0] PIPE_STAT_ADDR  = 8'h03;
   localparam logic [7:0] TOKEN_PIPE_ADDR = 8'h04;

   // Control and status register bit positions
   localparam int XC_PULLUP_BIT = 7;
   localparam int XC_PHY_ON_BIT = 6;
   localparam int XC_SPEED_BIT  = 5;
   localparam int XC_TEST_LSB   = 3;
   localparam int XC_DIFF_BIT   = 2;
   localparam int XC_DP_BIT     = 1;
   localparam int XC_DM_BIT     = 0;
   localparam int STAT_BAD_BIT  = 7;

   // ----------------------------------------------------------------
   // Endpoint and buffer geometry
   // ----------------------------------------------------------------
   localparam int          PIPE_COUNT  = 8;
   localparam int          PIPE_BITS   = 3;
   localparam int          PTR_BITS    = 7;
   localparam int          MEM_BYTES   = 1024;
   localparam int          MEM_ABITS   = 10;
   localparam int          BUF_DEPTH   = 2;
   localparam logic [7:0]  EP_DIR_MASK = 8'h80;
   localparam logic [1:0]  EP_MAX      = 2'h3;
   localparam logic [7:0]  XC_RESET    = 8'h00;

   // Test field encodings
   typedef enum logic [1:0] {
      TEST_NORMAL = 2'h0,
      TEST_DIFF1  = 2'h1,
      TEST_DIFF0  = 2'h2,
      TEST_SE0    = 2'h3
   } phy_test_t;

   // Software settings of the transceiver
   typedef struct packed {
      logic      pullup_enable;
      logic      phy_enable;
      logic      full_speed;
      phy_test_t phy_test_select;
   } xcvr_ctrl_t;

   // One sample of the two data lines
   typedef struct packed {
      logic dp;
      logic dm;
   } line_t;

   // Token seen by the serial engine
   typedef struct packed {
      logic [7:0] ep_addr;
      logic       is_in;
   } token_t;

endpackage

/* File: logic/endpoint_ram.sv */
// Single-port endpoint byte memory with registered read data
`timescale 1ns/1ps
module endpoint_ram
   import usb_xcvr_pkg::*;
(
   input  wire logic                 core_clk_in,
   input  wire logic                 cke_in,
   input  wire logic                 we_in,
   input  wire logic [MEM_ABITS-1:0] addr_in,
   input  wire logic [7:0]           wdata_in,
   output logic      [7:0]           rdata_out
);

   logic [7:0] store [MEM_BYTES];

   // Read first, a write returns the old byte; no reset so it maps to block RAM
   always_ff @(posedge core_clk_in) begin
      if (cke_in) begin
         if (we_in) begin
            store[addr_in] <= wdata_in;
         end
         rdata_out <= store[addr_in];
      end
   end

endmodule // endpoint_ram

/* File: logic/pair_buffer.sv */
// Two-entry valid/ready buffer between the receive stream and the memory
`timescale 1ns/1ps
module pair_buffer #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 2
) (
   input  wire logic             core_clk_in,
   input  wire logic             reset_n_in,
   input  wire logic             cke_in,
   input  wire logic             in_valid_in,
   output logic                  in_ready_out,
   input  wire logic [WIDTH-1:0] in_data_in,
   output logic                  out_valid_out,
   input  wire logic             out_ready_in,
   output logic      [WIDTH-1:0] out_data_out
);

   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam logic [AW:0] FULL = (AW+1)'(DEPTH);

   logic [WIDTH-1:0] slot [DEPTH];
   logic [AW-1:0]    wr_idx;
   logic [AW-1:0]    rd_idx;
   logic [AW:0]      count;
   logic             push;
   logic             pop;

   // Honest full and empty from the occupancy count
   assign in_ready_out  = (count != FULL);
   assign out_valid_out = (count != '0);
   assign out_data_out  = slot[rd_idx];
   assign push = cke_in && in_valid_in && in_ready_out;
   assign pop  = cke_in && out_valid_out && out_ready_in;

   // Slot storage, no reset needed for data
   always_ff @(posedge core_clk_in) begin
      if (push) begin
         slot[wr_idx] <= in_data_in;
      end
   end

   // Pointers wrap at the depth
   always_ff @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         wr_idx <= '0;
         rd_idx <= '0;
         count  <= '0;
      end else begin
         if (push) begin
            wr_idx <= (wr_idx == AW'(DEPTH - 1)) ? '0 : wr_idx + 1'b1;
         end
         if (pop) begin
            rd_idx <= (rd_idx == AW'(DEPTH - 1)) ? '0 : rd_idx + 1'b1;
         end
         count <= count + (AW+1)'(push) - (AW+1)'(pop);
      end
   end

endmodule // pair_buffer

/* File: logic/usb_function_controller.sv */
// USB function front end: endpoint decode, buffer and transceiver control
`timescale 1ns/1ps
module usb_function_controller
   import usb_xcvr_pkg::*;
(
   input  wire logic                core_clk_in,
   input  wire logic                reset_n_in,
   input  wire logic                cke_in,
   // Register port
   input  wire logic [7:0]          reg_addr_in,
   input  wire logic [7:0]          reg_wdata_in,
   input  wire logic                reg_wr_in,
   input  wire logic                reg_rd_in,
   output logic      [7:0]          reg_rdata_out,
   // Tokens and receive stream from the serial engine
   input  wire logic                tok_valid_in,
   input  wire usb_xcvr_pkg::token_t tok_in,
   input  wire logic                rx_valid_in,
   output logic                     rx_ready_out,
   input  wire logic [7:0]          rx_data_in,
   // Engine line drive in normal mode
   input  wire logic                sie_drive_in,
   input  wire usb_xcvr_pkg::line_t sie_line_in,
   // Pins
   input  wire logic                vbus_in,
   input  wire usb_xcvr_pkg::line_t line_in,
   output usb_xcvr_pkg::line_t      line_out,
   output logic                     line_oe_n_out,
   output logic                     pullup_dp_out,
   output logic                     pullup_dm_out,
   output logic                     phy_suspend_out,
   output logic [PIPE_BITS-1:0]     token_pipe_out,
   output logic                     token_hit_out
);

   import usb_xcvr_pkg::*;

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   xcvr_ctrl_t           ctrl;
   line_t                line_meta;
   line_t                line_sync;
   logic                 vbus_meta;
   logic                 vbus_sync;
   logic                 diff_state;
   logic [PIPE_BITS-1:0] pipe_sel;
   logic                 bad_token;
   logic [PTR_BITS-1:0]  wr_ptr [PIPE_COUNT];
   logic [PTR_BITS-1:0]  rd_ptr [PIPE_COUNT];
   logic [7:0]           rdata_reg;
   logic                 rd_from_mem;
   logic [7:0]           mem_rdata;

   // ----------------------------------------------------------------
   // Register decode
   // ----------------------------------------------------------------
   logic wr_ctrl;
   logic wr_sel;
   logic wr_stat;
   logic rd_data;

   assign wr_ctrl = cke_in && reg_wr_in && (reg_addr_in == XCVR_CTRL_ADDR);
   assign wr_sel  = cke_in && reg_wr_in && (reg_addr_in == PIPE_SEL_ADDR);
   assign wr_stat = cke_in && reg_wr_in && (reg_addr_in == PIPE_STAT_ADDR);
   assign rd_data = cke_in && reg_rd_in && (reg_addr_in == PIPE_DATA_ADDR);

   // Control settings live in one register, reset detached and suspended
   always_ff @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         ctrl <= xcvr_ctrl_t'(XC_RESET[7:3]);
      end else if (wr_ctrl) begin
         ctrl <= xcvr_ctrl_t'(reg_wdata_in[7:3]);
      end
   end

   // Pipe picked by firmware for draining
   always_ff @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         pipe_sel <= '0;
      end else if (wr_sel) begin
         pipe_sel <= reg_wdata_in[PIPE_BITS-1:0];
      end
   end

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   // Lines and VBUS are asynchronous to the core clock
   always_ff @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         line_meta <= '0;
         line_sync <= '0;
         vbus_meta <= 1'b0;
         vbus_sync <= 1'b0;
      end else if (cke_in) begin
         line_meta <= line_in;
         line_sync <= line_meta;
         vbus_meta <= vbus_in;
         vbus_sync <= vbus_meta;
      end
   end

   // Differential receiver holds its last J/K value through SE0
   always_ff @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         diff_state <= 1'b0;
      end else if (cke_in) begin
         if (!ctrl.phy_enable) begin
            diff_state <= 1'b0;
         end else if (line_sync.dp != line_sync.dm) begin
            diff_state <= line_sync.dp;
         end
      end
   end

   // ----------------------------------------------------------------
   // Transceiver outputs
   // ----------------------------------------------------------------
   // Suspend follows the enable; firmware starts the clock first
   assign phy_suspend_out = !ctrl.phy_enable;

   // Pull-up side chosen by speed, gated by VBUS presence
   assign pullup_dp_out = ctrl.pullup_enable && vbus_sync
                          && ctrl.full_speed;
   assign pullup_dm_out = ctrl.pullup_enable && vbus_sync
                          && !ctrl.full_speed;

   // Test forcing overrides the engine; nothing drives while suspended
   always_comb begin
      line_out      = sie_line_in;
      line_oe_n_out = !(ctrl.phy_enable && sie_drive_in);
      if (ctrl.phy_enable) begin
         unique case (ctrl.phy_test_select)
            TEST_NORMAL: begin
               line_out = sie_line_in;
            end
            TEST_DIFF1: begin
               line_out      = '{dp: 1'b1, dm: 1'b0};
               line_oe_n_out = 1'b0;
            end
            TEST_DIFF0: begin
               line_out      = '{dp: 1'b0, dm: 1'b1};
               line_oe_n_out = 1'b0;
            end
            TEST_SE0: begin
               line_out      = '{dp: 1'b0, dm: 1'b0};
               line_oe_n_out = 1'b0;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Endpoint address decode
   // ----------------------------------------------------------------
   // Tokens only come in; this block never sources one or a frame mark
   logic [PIPE_BITS-1:0] next_pipe;
   logic                 next_ok;

   always_comb begin
      next_pipe = '0;
      next_ok   = 1'b0;
      if ((tok_in.ep_addr & ~EP_DIR_MASK) == 8'h00) begin
         // Endpoint zero: one address, direction from token kind
         next_ok   = (tok_in.ep_addr == 8'h00);
         next_pipe = {2'h0, tok_in.is_in};
      end else if (tok_in.ep_addr[6:2] == 5'h00) begin
         // Bit 7 marks the IN pipe of endpoints one to three
         next_ok   = (tok_in.ep_addr[7] == tok_in.is_in);
         next_pipe = {tok_in.ep_addr[1:0], tok_in.ep_addr[7]};
      end
   end

   // Latched pipe, 8 in all: index is endpoint number and direction
   always_ff @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         token_pipe_out <= '0;
         token_hit_out  <= 1'b0;
      end else if (cke_in && tok_valid_in) begin
         token_hit_out <= next_ok;
         if (next_ok) begin
            token_pipe_out <= next_pipe;
         end
      end
   end

   // Sticky bad token flag; a new event beats a clear in the same cycle
   always_ff @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         bad_token <= 1'b0;
      end else if (cke_in && tok_valid_in && !next_ok) begin
         bad_token <= 1'b1;
      end else if (wr_stat && reg_wdata_in[STAT_BAD_BIT]) begin
         bad_token <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Receive path into the 1 kB buffer
   // ----------------------------------------------------------------
   logic       buf_valid;
   logic       buf_ready;
   logic [7:0] buf_data;
   logic       mem_we;

   pair_buffer #(
      .WIDTH (8),
      .DEPTH (BUF_DEPTH)
   ) u_rx_buf (
      .core_clk_in   (core_clk_in),
      .reset_n_in    (reset_n_in),
      .cke_in        (cke_in),
      .in_valid_in   (rx_valid_in),
      .in_ready_out  (rx_ready_out),
      .in_data_in    (rx_data_in),
      .out_valid_out (buf_valid),
      .out_ready_in  (buf_ready),
      .out_data_out  (buf_data)
   );

   // Firmware reads own the single port, so the drain stalls then
   assign buf_ready = !rd_data;
   assign mem_we    = cke_in && buf_valid && buf_ready;

   logic [MEM_ABITS-1:0] mem_addr;

   assign mem_addr = rd_data ? {pipe_sel, rd_ptr[pipe_sel]}
                             : {token_pipe_out, wr_ptr[token_pipe_out]};

   endpoint_ram u_ram (
      .core_clk_in (core_clk_in),
      .cke_in      (cke_in),
      .we_in       (mem_we),
      .addr_in     (mem_addr),
      .wdata_in    (buf_data),
      .rdata_out   (mem_rdata)
   );

   // Per pipe pointers, 128 bytes each, wrapping
   genvar p;
   generate
      for (p = 0; p < PIPE_COUNT; p++) begin : g_pipe
         always_ff @(posedge core_clk_in or negedge reset_n_in) begin
            if (!reset_n_in) begin
               wr_ptr[p] <= '0;
               rd_ptr[p] <= '0;
            end else begin
               if (mem_we && token_pipe_out == PIPE_BITS'(p)) begin
                  wr_ptr[p] <= wr_ptr[p] + 1'b1;
               end
               if (rd_data && pipe_sel == PIPE_BITS'(p)) begin
                  rd_ptr[p] <= rd_ptr[p] + 1'b1;
               end
            end
         end
      end
   endgenerate

   // ----------------------------------------------------------------
   // Register read
   // ----------------------------------------------------------------
   // Answer lands the cycle after the strobe; unmapped reads give zero
   always_ff @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         rdata_reg   <= '0;
         rd_from_mem <= 1'b0;
      end else if (cke_in) begin
         rd_from_mem <= rd_data;
         rdata_reg   <= '0;
         if (reg_rd_in) begin
            unique case (reg_addr_in)
               XCVR_CTRL_ADDR: begin
                  rdata_reg <= {ctrl, diff_state, line_sync};
               end
               PIPE_SEL_ADDR: begin
                  rdata_reg <= {5'h00, pipe_sel};
               end
               PIPE_STAT_ADDR: begin
                  rdata_reg <= {bad_token,
                                wr_ptr[pipe_sel] - rd_ptr[pipe_sel]};
               end
               TOKEN_PIPE_ADDR: begin
                  rdata_reg <= {token_hit_out, 4'h0, token_pipe_out};
               end
               default: begin
                  rdata_reg <= '0;
               end
            endcase
         end
      end
   end

   assign reg_rdata_out = rd_from_mem ? mem_rdata : rdata_reg;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   a_pullup_vbus_gate: assert property (
      @(posedge core_clk_in) disable iff (!reset_n_in)
      (pullup_dp_out || pullup_dm_out) |-> vbus_sync && ctrl.pullup_enable)
      else $error("pull-up on without VBUS or enable");

   a_pullup_full_dp: assert property (
      @(posedge core_clk_in) disable iff (!reset_n_in)
      ctrl.pullup_enable && vbus_sync && ctrl.full_speed
      |-> pullup_dp_out && !pullup_dm_out)
      else $error("full speed pull-up not on D+");

   a_pullup_low_dm: assert property (
      @(posedge core_clk_in) disable iff (!reset_n_in)
      ctrl.pullup_enable && vbus_sync && !ctrl.full_speed
      |-> pullup_dm_out && !pullup_dp_out)
      else $error("low speed pull-up not on D-");

   a_pullup_off_detach: assert property (
      @(posedge core_clk_in) disable iff (!reset_n_in)
      !ctrl.pullup_enable |-> !pullup_dp_out && !pullup_dm_out)
      else $error("pull-up on while disabled");

   a_suspend_no_drive: assert property (
      @(posedge core_clk_in) disable iff (!reset_n_in)
      !ctrl.phy_enable |-> line_oe_n_out && phy_suspend_out)
      else $error("lines driven while suspended");

   a_test_line_force: assert property (
      @(posedge core_clk_in) disable iff (!reset_n_in)
      ctrl.phy_enable && ctrl.phy_test_select != TEST_NORMAL
      |-> !line_oe_n_out
          && line_out.dp == (ctrl.phy_test_select == TEST_DIFF1)
          && line_out.dm == (ctrl.phy_test_select == TEST_DIFF0))
      else $error("forced line state wrong");

   a_decode_ep_zero: assert property (
      @(posedge core_clk_in) disable iff (!reset_n_in)
      cke_in && tok_valid_in && tok_in.ep_addr == 8'h00
      |=> token_hit_out && token_pipe_out == {2'h0, $past(tok_in.is_in)})
      else $error("endpoint zero decode wrong");

   a_decode_in_pipe: assert property (
      @(posedge core_clk_in) disable iff (!reset_n_in)
      cke_in && tok_valid_in && tok_in.is_in && tok_in.ep_addr == 8'h83
      |=> token_hit_out && token_pipe_out == 3'h7)
      else $error("IN pipe of endpoint three decode wrong");

   a_diff_status: assert property (
      @(posedge core_clk_in) disable iff (!reset_n_in)
      cke_in && ctrl.phy_enable && line_sync.dp && !line_sync.dm
      |=> diff_state)
      else $error("differential status not one");

endmodule // usb_function_controller

/* File: tb/usb_host_model.sv */
// Behavioural USB host: tokens, OUT data bytes and bus line levels
`timescale 1ns/1ps
module usb_host_model
   import usb_xcvr_pkg::*;
(
   input  wire logic          clk_in,
   input  wire logic          rx_ready_in,
   output logic               tok_valid_out,
   output usb_xcvr_pkg::token_t tok_out,
   output logic               rx_valid_out,
   output logic [7:0]         rx_data_out,
   output usb_xcvr_pkg::line_t line_out
);
   import usb_xcvr_pkg::*;

   // Idle levels at time zero; bus idles in the full speed J state
   initial begin
      tok_valid_out = 1'b0;
      tok_out       = '0;
      rx_valid_out  = 1'b0;
      rx_data_out   = 8'h00;
      line_out      = '{1'b1, 1'b0};
   end

   // Only the host side issues tokens; the device merely decodes them
   task automatic token(input logic [7:0] ep, input logic is_in);
      @(posedge clk_in);
      tok_valid_out <= 1'b1;
      tok_out       <= '{ep, is_in};
      @(posedge clk_in);
      tok_valid_out <= 1'b0;
      tok_out       <= '{~ep, ~is_in}; // Stale token scrambled
   endtask

   // Back-to-back OUT bytes, each held until the device takes it
   task automatic burst(input logic [7:0] first, input int n);
      int i;
      @(posedge clk_in);
      for (i = 0; i < n; i++) begin
         rx_valid_out <= 1'b1;
         rx_data_out  <= first + 8'(i);
         @(posedge clk_in);
         while (!rx_ready_in) @(posedge clk_in);
      end
      rx_valid_out <= 1'b0;
      rx_data_out  <= ~rx_data_out; // Released data no longer valid
   endtask

   // Line levels the host presents on D+ and D-
   task automatic set_line(input usb_xcvr_pkg::line_t l);
      @(posedge clk_in);
      line_out <= l;
   endtask
endmodule // usb_host_model

/* File: tb/usb_function_controller_test.sv */
// Self-checking bench for the USB function front end
`timescale 1ns/1ps
module usb_function_controller_test;
   import usb_xcvr_pkg::*;
   logic       core_clk_in, reset_n_in, reg_wr_in, reg_rd_in, vbus_in;
   logic       tok_valid_in, rx_valid_in, rx_ready_out, sie_drive_in;
   logic       line_oe_n_out, pullup_dp_out, pullup_dm_out;
   logic       phy_suspend_out, token_hit_out, cke_in;
   logic [7:0] reg_addr_in, reg_wdata_in, reg_rdata_out, rx_data_in;
   logic [7:0] rd_data, eps [8];
   logic [2:0] token_pipe_out, lines [4];
   token_t     tok_in;
   line_t      line_in, line_out, sie_line_in;
   int         fails, comparisons, i;
   logic       dir;

   // ------------------------------------------------------------
   // Design, far-side host and clock
   // ------------------------------------------------------------
   usb_function_controller dut (.core_clk_in(core_clk_in),
      .reset_n_in(reset_n_in), .cke_in(cke_in), .reg_addr_in(reg_addr_in),
      .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
      .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
      .tok_valid_in(tok_valid_in), .tok_in(tok_in),
      .rx_valid_in(rx_valid_in), .rx_ready_out(rx_ready_out),
      .rx_data_in(rx_data_in), .sie_drive_in(sie_drive_in),
      .sie_line_in(sie_line_in), .vbus_in(vbus_in), .line_in(line_in),
      .line_out(line_out), .line_oe_n_out(line_oe_n_out),
      .pullup_dp_out(pullup_dp_out), .pullup_dm_out(pullup_dm_out),
      .phy_suspend_out(phy_suspend_out),
      .token_pipe_out(token_pipe_out), .token_hit_out(token_hit_out));
   usb_host_model host (.clk_in(core_clk_in), .rx_ready_in(rx_ready_out),
      .tok_valid_out(tok_valid_in), .tok_out(tok_in),
      .rx_valid_out(rx_valid_in), .rx_data_out(rx_data_in),
      .line_out(line_in));

   initial begin
      core_clk_in = 1'b0;
      forever #25 core_clk_in = ~core_clk_in;
   end

   // ------------------------------------------------------------
   // Register access, comparison and verdict
   // ------------------------------------------------------------
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk_in);
      reg_wr_in    <= 1'b1;
      reg_addr_in  <= a;
      reg_wdata_in <= d;
      @(posedge core_clk_in);
      reg_wr_in    <= 1'b0;
   endtask

   // Read data stands only in the cycle after the strobe
   task automatic rd(input logic [7:0] a);
      @(posedge core_clk_in);
      reg_rd_in   <= 1'b1;
      reg_addr_in <= a;
      @(posedge core_clk_in);
      reg_rd_in   <= 1'b0;
      #1 rd_data = reg_rdata_out;
   endtask

   task automatic check(input string what, input logic [7:0] seen,
                        input logic [7:0] expect_v);
      comparisons++;
      if (seen !== expect_v) begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", what, expect_v,
                  seen);
      end
   endtask

   task automatic close_out();
      $display("comparisons %0d mismatches %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // Watchdog at 40000 cycles, well beyond the hundred or so cycles the tests need
   initial begin
      #2000000;
      fails++;
      close_out();
   end

   // ------------------------------------------------------------
   // Test sequence
   // ------------------------------------------------------------
   initial begin
      {reset_n_in, reg_wr_in, reg_rd_in, vbus_in} = 4'h0;
      {reg_addr_in, reg_wdata_in} = 16'h0000;
      sie_drive_in = 1'b1;
      cke_in       = 1'b1;
      sie_line_in  = '{1'b1, 1'b1};
      eps   = '{8'h00, 8'h00, 8'h01, 8'h02, 8'h03, 8'h81, 8'h82, 8'h83};
      lines = '{3'b110, 3'b100, 3'b010, 3'b000};
      repeat (2) @(posedge core_clk_in);
      #1 check("reset pins", {3'h0, phy_suspend_out, line_oe_n_out,
         pullup_dp_out, pullup_dm_out, rx_ready_out}, 8'h19);
      @(posedge core_clk_in);
      reset_n_in <= 1'b1;
      rd(XCVR_CTRL_ADDR);
      check("ctrl reset", rd_data, 8'h00);
      // Pull-up placement by speed and VBUS; clock already runs
      vbus_in <= 1'b1;
      wr(XCVR_CTRL_ADDR, 8'he0);
      repeat (3) @(posedge core_clk_in);
      check("full speed", {pullup_dp_out, pullup_dm_out}, 8'h02);
      rd(XCVR_CTRL_ADDR);
      check("ctrl bits", rd_data & 8'hf8, 8'he0);
      wr(XCVR_CTRL_ADDR, 8'hc0);
      #1 check("low speed", {pullup_dp_out, pullup_dm_out}, 8'h01);
      vbus_in <= 1'b0;
      repeat (3) @(posedge core_clk_in);
      check("no vbus", {pullup_dp_out, pullup_dm_out}, 8'h00);
      vbus_in <= 1'b1;
      wr(XCVR_CTRL_ADDR, 8'h20);
      repeat (3) @(posedge core_clk_in);
      check("detached", {phy_suspend_out, pullup_dp_out, pullup_dm_out},
            8'h04);
      // Every test mode, phy enabled; mode zero follows the engine
      for (i = 0; i < 4; i++) begin
         wr(XCVR_CTRL_ADDR, 8'h40 | 8'(i << 3));
         #1 check("test lines", {5'h0, line_out, line_oe_n_out},
                  {5'h0, lines[i]});
      end
      // Back to normal mode before watching the host's line levels
      wr(XCVR_CTRL_ADDR, 8'h40);
      check("awake", {7'h0, phy_suspend_out}, 8'h00);
      sie_drive_in <= 1'b0;
      host.set_line('{1'b1, 1'b0});
      repeat (3) @(posedge core_clk_in);
      rd(XCVR_CTRL_ADDR);
      check("diff one", rd_data, 8'h46);
      host.set_line('{1'b0, 1'b1});
      repeat (3) @(posedge core_clk_in);
      rd(XCVR_CTRL_ADDR);
      check("diff zero", rd_data, 8'h41);
      // All eight pipes, then an IN token to an OUT address leaves the pipe alone
      for (i = 0; i < 8; i++) begin
         dir = eps[i][7] | (i == 1);
         host.token(eps[i], dir);
         #1 check("pipe", {token_hit_out, 4'h0, token_pipe_out},
                  {1'b1, 4'h0, eps[i][1:0], dir});
      end
      host.token(8'h01, 1'b1);
      rd(TOKEN_PIPE_ADDR);
      check("bad token", rd_data, 8'h07);
      rd(PIPE_STAT_ADDR);
      check("bad flag", rd_data & 8'h80, 8'h80);
      wr(PIPE_STAT_ADDR, 8'h80);
      // Bytes into endpoint two OUT, read back in order
      host.token(8'h02, 1'b0);
      wr(PIPE_SEL_ADDR, 8'h04);
      host.burst(8'ha1, 3);
      repeat (3) @(posedge core_clk_in);
      rd(PIPE_STAT_ADDR);
      check("fill", rd_data, 8'h03);
      for (i = 0; i < 3; i++) begin
         rd(PIPE_DATA_ADDR);
         check("pipe byte", rd_data, 8'ha1 + 8'(i));
      end
      rd(PIPE_STAT_ADDR);
      check("drained", rd_data, 8'h00);
      // Clock enable low freezes state, so this write must be lost
      cke_in <= 1'b0;
      wr(PIPE_SEL_ADDR, 8'h01);
      cke_in <= 1'b1;
      rd(PIPE_SEL_ADDR);
      check("frozen", rd_data, 8'h04);
      wr(8'h55, 8'hff);
      rd(8'h55);
      check("unmapped", rd_data, 8'h00);
      close_out();
   end
endmodule // usb_function_controller_test
